// File: src/tlr_pkg.sv
// Purpose: Shared constants and types for the temperature limit register bank
// Assumes: Two-wire serial slave, pointer selected limit registers
// Notes: Mask function serves both the write path and the read path
package tlr_pkg;
  // ==================================================
  // Bus framing
  localparam logic [3:0] DEV_ADDR_FIXED = 4'h9; // Fixed upper address bits 1001
  localparam logic [3:0] BIT_LAST = 4'h8; // Bits per byte on the wire
  localparam logic [1:0] WCNT_EXTRA = 2'h2; // Data bytes past the second
  // ==================================================
  // Register map
  localparam logic [7:0] PTR_LOW = 8'h02; // Lower alarm limit
  localparam logic [7:0] PTR_HIGH = 8'h03; // Upper alarm limit
  localparam logic [7:0] PTR_RESET = 8'h00; // Pointer after reset
  localparam logic [15:0] KEEP_9BIT_LSB = 16'h007f; // Unused bits at 9-bit resolution
  // ==================================================
  // Carriers
  typedef struct packed {
    logic [15:0] high; // Upper threshold
    logic [15:0] low; // Lower threshold
  } tlr_limits_type;
  typedef struct packed {
    logic busy; // Nonvolatile copy in progress
    logic lock; // Reversible lock
    logic lockdown; // Permanent lockdown
  } tlr_guard_type;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACK_ADDR = 9'h004,
    ST_PTR = 9'h008,
    ST_ACK_PTR = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_WDATA = 9'h040,
    ST_RDATA = 9'h080,
    ST_ACK_MST = 9'h100
  } tlr_state_type;
  // Bits kept for a resolution code 0..3 (9 to 12 bits)
  function automatic logic [15:0] tlr_res_mask(input logic [1:0] res);
    tlr_res_mask = ~(KEEP_9BIT_LSB >> res);
  endfunction
endpackage

// File: src/tlr_top.sv
// Purpose: Volatile alarm limit registers behind a two-wire serial slave
// Assumes: Pins arrive asynchronously; guard and resolution come from this clock
// Notes: Open-drain data pin split into value, enable and input
`timescale 1ns/10ps
// Functional notes
// (RULE1) Limits are 16-bit two's complement, sign bit 15
// (RULE2) Write keeps resolution bits, zeroes lower bits
// (RULE3) Read returns resolution bits, lower bits zero
// (RULE4) Acknowledge matching write address with strap bits
// (RULE5) Acknowledge pointer byte selecting low or high
// (RULE6) Two data bytes form value; extras ignored
// (RULE7) Stop or restart before two bytes discards data
// (RULE8) Busy, lock or lockdown refuses limit change
// (RULE9) Locked writes acked; busy nacks data bytes
// (RULE10) Pointer persists across transfers
// (RULE11) Read address acked, upper byte shifted first
// (RULE12) Master nack after lower byte releases line
// (RULE13) Master ack after lower byte repeats register
// (RULE14) Reset loads limits from nonvolatile copies
// (RULE15) Master keeps high limit above low limit
// (RULE16) Limit value change clears fault counter
// (RULE17) Limits feed the alarm thresholds
// (RULE18) Alarm uses volatile limits, not nonvolatile copies
// (RULE19) First data byte is bits 15..8, MSB first
// (RULE20) Masking uses resolution at second byte end
module tlr_top #(
  parameter int SYNC_STAGES = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] addr_pins_i,
  input wire logic resolution_select_hi_i,
  input wire logic resolution_select_lo_i,
  input wire tlr_pkg::tlr_guard_type guard_i,
  input wire tlr_pkg::tlr_limits_type nv_limits_i,
  output tlr_pkg::tlr_limits_type alarm_limits_o,
  output logic fault_count_clear_o
);
  // ==================================================
  // Pin synchronisers
  logic [SYNC_STAGES-1:0] sync_q [5]; // Per pin shift chain
  logic [SYNC_STAGES-1:0] sync_d [5];
  logic [4:0] filt_q; // Agreed pin levels
  logic [4:0] filt_d;
  logic [4:0] prev_q; // Levels one cycle back
  logic [4:0] pins;

  assign pins = {scl_i, sda_i, addr_pins_i};

  // Shift pins in, accept a level once the last two stages agree
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      sync_d[i] = {sync_q[i][SYNC_STAGES-2:0], pins[i]};
      filt_d[i] = filt_q[i];
      if (sync_q[i][SYNC_STAGES-1] == sync_q[i][SYNC_STAGES-2]) begin
        filt_d[i] = sync_q[i][SYNC_STAGES-1];
      end
    end
  end

  // Idle bus is high on both wires
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < 5; i++) begin
        sync_q[i] <= '1;
      end
      filt_q <= 5'h1f;
      prev_q <= 5'h1f;
    end else begin
      sync_q <= sync_d;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  // ==================================================
  // Bus conditions
  logic scl_f; // Filtered clock
  logic sda_f; // Filtered data
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [1:0] res; // Current resolution code
  logic blocked; // Limit change refused

  assign scl_f = filt_q[4];
  assign sda_f = filt_q[3];
  assign scl_rise = scl_f && !prev_q[4];
  assign scl_fall = !scl_f && prev_q[4];
  // Data moving while clock is high frames a transfer
  assign start_seen = scl_f && prev_q[4] && prev_q[3] && !sda_f;
  assign stop_seen = scl_f && prev_q[4] && !prev_q[3] && sda_f;
  assign res = {resolution_select_hi_i, resolution_select_lo_i};
  assign blocked = guard_i.busy || guard_i.lock || guard_i.lockdown; // RULE8

  // ==================================================
  // Transfer engine and limit registers
  tlr_pkg::tlr_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d; // Bits seen in this byte
  logic [7:0] sh_q, sh_d; // Receive shifter
  logic [7:0] ptr_q, ptr_d; // Register pointer
  logic [7:0] hold_q, hold_d; // First data byte
  logic [1:0] wcnt_q, wcnt_d; // Data bytes in this write
  logic rd_q, rd_d; // Transfer is a read
  logic bsel_q, bsel_d; // Lower byte being sent
  logic [7:0] tx_q, tx_d; // Transmit shifter
  logic drive_q, drive_d; // Pulling data low
  logic more_q, more_d; // Master acked last byte
  tlr_pkg::tlr_limits_type lim_q, lim_d; // RULE1
  logic fclr_q, fclr_d;
  logic commit;
  logic [15:0] new_word;
  logic [15:0] rd_word;

  // Assembled write word, masked by resolution at this moment
  assign new_word = {hold_q, sh_q} & tlr_pkg::tlr_res_mask(res); // RULE19 RULE20 RULE2

  // Unmapped pointers read as zero here; other registers live elsewhere
  always_comb begin
    rd_word = 16'h0000;
    if (ptr_q == tlr_pkg::PTR_LOW) begin
      rd_word = lim_q.low;
    end else if (ptr_q == tlr_pkg::PTR_HIGH) begin
      rd_word = lim_q.high;
    end
    rd_word = rd_word & tlr_pkg::tlr_res_mask(res); // RULE3
  end

  // Next state of the byte engine
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    hold_d = hold_q;
    wcnt_d = wcnt_q;
    rd_d = rd_q;
    bsel_d = bsel_q;
    tx_d = tx_q;
    drive_d = drive_q;
    more_d = more_q;
    lim_d = lim_q;
    commit = 1'b0;
    if (start_seen) begin
      // Restart abandons any partial write
      st_d = tlr_pkg::ST_ADDR; // RULE7
      cnt_d = 4'h0;
      drive_d = 1'b0;
      wcnt_d = 2'h0;
    end else if (stop_seen) begin
      st_d = tlr_pkg::ST_IDLE; // RULE7
      drive_d = 1'b0;
    end else begin
      case (st_q)
        tlr_pkg::ST_ADDR, tlr_pkg::ST_PTR, tlr_pkg::ST_WDATA: begin
          if (scl_rise) begin
            // MSB first on the wire
            sh_d = {sh_q[6:0], sda_f}; // RULE19
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == tlr_pkg::BIT_LAST) begin
            cnt_d = 4'h0;
            if (st_q == tlr_pkg::ST_ADDR) begin
              if (sh_q[7:1] == {tlr_pkg::DEV_ADDR_FIXED, filt_q[2:0]}) begin
                st_d = tlr_pkg::ST_ACK_ADDR; // RULE4 RULE11
                drive_d = 1'b1;
                rd_d = sh_q[0];
              end else begin
                // Not ours: stay off the bus until the next start
                st_d = tlr_pkg::ST_IDLE;
              end
            end else if (st_q == tlr_pkg::ST_PTR) begin
              ptr_d = sh_q; // RULE10
              st_d = tlr_pkg::ST_ACK_PTR; // RULE5
              drive_d = 1'b1;
            end else begin
              st_d = tlr_pkg::ST_ACK_WDATA;
              drive_d = !guard_i.busy; // RULE9
              if (wcnt_q == 2'h0) begin
                hold_d = sh_q; // RULE19
              end
              if (wcnt_q == 2'h1 && !blocked) begin
                commit = 1'b1; // RULE6 RULE8
              end
              if (wcnt_q != tlr_pkg::WCNT_EXTRA) begin
                wcnt_d = wcnt_q + 2'h1; // RULE6
              end
            end
          end
        end
        tlr_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (rd_q) begin
              // Upper byte leads every read
              bsel_d = 1'b0;
              tx_d = rd_word[15:8]; // RULE11
              drive_d = !rd_word[15];
              st_d = tlr_pkg::ST_RDATA;
            end else begin
              drive_d = 1'b0;
              st_d = tlr_pkg::ST_PTR;
            end
          end
        end
        tlr_pkg::ST_ACK_PTR, tlr_pkg::ST_ACK_WDATA: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            st_d = tlr_pkg::ST_WDATA;
          end
        end
        tlr_pkg::ST_RDATA: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == tlr_pkg::BIT_LAST) begin
              // Free the line for the master's ack bit
              drive_d = 1'b0;
              st_d = tlr_pkg::ST_ACK_MST;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              drive_d = !tx_q[6];
            end
          end
        end
        tlr_pkg::ST_ACK_MST: begin
          if (scl_rise) begin
            more_d = !sda_f;
          end else if (scl_fall) begin
            if (more_q) begin
              // After the lower byte wrap back to the upper one
              bsel_d = !bsel_q; // RULE13
              tx_d = bsel_q ? rd_word[15:8] : rd_word[7:0];
              drive_d = bsel_q ? !rd_word[15] : !rd_word[7];
              cnt_d = 4'h0;
              st_d = tlr_pkg::ST_RDATA;
            end else begin
              // Nack ends the read; line stays released
              st_d = tlr_pkg::ST_IDLE; // RULE12
            end
          end
        end
        default: begin
          st_d = tlr_pkg::ST_IDLE;
        end
      endcase
    end
    if (commit && ptr_q == tlr_pkg::PTR_LOW) begin
      lim_d.low = new_word; // RULE2
    end else if (commit && ptr_q == tlr_pkg::PTR_HIGH) begin
      lim_d.high = new_word; // RULE2
    end
    // Rewriting an equal value leaves the fault count alone
    fclr_d = (lim_d != lim_q); // RULE16
  end

  // Reset copies the nonvolatile limits in
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= tlr_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= tlr_pkg::PTR_RESET;
      hold_q <= 8'h00;
      wcnt_q <= 2'h0;
      rd_q <= 1'b0;
      bsel_q <= 1'b0;
      tx_q <= 8'h00;
      drive_q <= 1'b0;
      more_q <= 1'b0;
      lim_q <= nv_limits_i; // RULE14
      fclr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      hold_q <= hold_d;
      wcnt_q <= wcnt_d;
      rd_q <= rd_d;
      bsel_q <= bsel_d;
      tx_q <= tx_d;
      drive_q <= drive_d;
      more_q <= more_d;
      lim_q <= lim_d;
      fclr_q <= fclr_d;
    end
  end

  // ==================================================
  // Outputs
  assign sda_o = 1'b0; // Open drain: only ever pulls low
  assign sda_oe_o = drive_q;
  assign alarm_limits_o = lim_q; // RULE17 RULE18
  assign fault_count_clear_o = fclr_q; // RULE16

  // ==================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_refused_stable: assert property (blocked |=> $stable(lim_q)) // RULE8
    else $error("limit changed while write refused");
  // Only the written register; the other may still hold unmasked reset data
  a_write_masked: assert property (commit && // RULE2
    (ptr_q == tlr_pkg::PTR_LOW || ptr_q == tlr_pkg::PTR_HIGH) |=>
    ((($past(ptr_q) == tlr_pkg::PTR_LOW) ? lim_q.low : lim_q.high) <<
    ({3'h0, $past(res)} + 5'h9)) == 16'h0000)
    else $error("written limit keeps masked bits");
  a_read_masked: assert property ($rose(st_q == tlr_pkg::ST_RDATA) && bsel_q |-> // RULE3
    (tx_q << ({1'b0, $past(res)} + 3'h1)) == 8'h00)
    else $error("read lower byte has masked bits");
  a_addr_ack: assert property (st_q == tlr_pkg::ST_ACK_ADDR |-> drive_q) // RULE4
    else $error("address not acknowledged");
  a_ptr_ack: assert property (st_q == tlr_pkg::ST_ACK_PTR |-> drive_q) // RULE5
    else $error("pointer not acknowledged");
  a_commit_second: assert property (commit |-> wcnt_q == 2'h1 && !blocked) // RULE6
    else $error("commit on wrong data byte");
  a_busy_nack: assert property ($rose(st_q == tlr_pkg::ST_ACK_WDATA) |-> // RULE9
    drive_q == !$past(guard_i.busy))
    else $error("data ack does not follow busy");
  a_ptr_keep: assert property ($changed(ptr_q) |-> $past(st_q) == tlr_pkg::ST_PTR) // RULE10
    else $error("pointer changed outside pointer byte");
  a_fault_clear: assert property ($changed(lim_q) |-> fault_count_clear_o) // RULE16
    else $error("limit change without fault clear");
  a_nack_release: assert property (st_q == tlr_pkg::ST_ACK_MST && scl_fall && !more_q // RULE12
    |=> !drive_q [*2])
    else $error("line held after master nack");

  c_commit: cover property (commit);
  c_repeat_read: cover property (st_q == tlr_pkg::ST_ACK_MST && scl_fall && more_q && bsel_q);
  c_busy_nack: cover property (st_q == tlr_pkg::ST_ACK_WDATA && !drive_q);
endmodule

// File: dv/tlr_master.sv
// Purpose: Behavioural two-wire bus master for the limit register bank
// Assumes: A released data line is pulled high; each level held 8+ clocks
// Notes: All traffic comes from task calls made by the bench
`timescale 1ns/10ps
module tlr_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ==================================================
  // Bus primitives
  initial begin
    scl_o = 1'b1; // Idle bus, both lines released
    sda_o = 1'b1;
  end
  // Wait n clocks, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Start or repeated start, data falls while clock high
  task automatic start();
    sda_o = 1'b1;
    hold(8);
    scl_o = 1'b1;
    hold(8);
    sda_o = 1'b0;
    hold(8);
    scl_o = 1'b0;
    hold(8);
  endtask
  // Stop, data rises while clock high
  task automatic stop();
    sda_o = 1'b0;
    hold(8);
    scl_o = 1'b1;
    hold(8);
    sda_o = 1'b1;
    hold(8);
  endtask
  // One bit; set up while clock low, sampled mid-high
  task automatic bit_x(input logic v, output logic r);
    sda_o = v;
    hold(8);
    scl_o = 1'b1;
    hold(5);
    r = sda_i;
    hold(5);
    scl_o = 1'b0;
    hold(8);
  endtask
  // Eight bits MSB first, then the ack bit
  task automatic xfer(input logic [7:0] w, input logic ack_v, output logic [7:0] r,
      output logic ack_r);
    for (int i = 7; i >= 0; i--) begin
      bit_x(w[i], r[i]);
    end
    bit_x(ack_v, ack_r);
  endtask
endmodule

// File: dv/temp_limit_register_access_bench.sv
// Purpose: Self-checking bench for the limit register bank
// Assumes: Master model drives the bus; bench holds guard and resolution
// Notes: Expected limits come from an integer model of masking and refusal
`timescale 1ns/10ps
module temp_limit_register_access_bench;
  // ==================================================
  // Signals and model state
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic scl, sda_m, sda_o, sda_oe_o, fault_count_clear_o;
  logic sda_w; // Wired-and line
  logic [2:0] apins = 3'h0;
  logic res_hi = 1'b0;
  logic res_lo = 1'b0;
  tlr_pkg::tlr_guard_type guard = 3'h0;
  tlr_pkg::tlr_limits_type nv = 32'h0;
  tlr_pkg::tlr_limits_type lim;
  logic [31:0] seed = 32'h26; // Xorshift seed 38
  logic [31:0] t;
  int fails = 0;
  int total_checks = 0;
  int pulses = 0; // Fault clear pulses seen
  int exp_lo, exp_hi, ptr, res;
  // Pull-up unless someone pulls low
  assign sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  tlr_top tlr_top_i (.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_pins_i(apins), .resolution_select_hi_i(res_hi),
    .resolution_select_lo_i(res_lo), .guard_i(guard), .nv_limits_i(nv),
    .alarm_limits_o(lim), .fault_count_clear_o(fault_count_clear_o));
  tlr_master tlr_master_i (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  // Count single-cycle clear pulses
  always @(posedge clk_i) begin
    if (fault_count_clear_o === 1'b1) begin
      pulses++;
    end
  end
  // ==================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Keep 9+res upper bits
  function automatic int msk(input int v);
    return (v >> (7 - res)) << (7 - res);
  endfunction
  task automatic chk16(input logic [15:0] got, input int e);
    total_checks++;
    if (got !== 16'(e)) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, got, 16'(e));
    end
  endtask
  task automatic chk1(input logic got, input logic e);
    total_checks++;
    if (got !== e) begin
      fails++;
      $display("MISMATCH %0t bit got %b want %b", $time, got, e);
    end
  endtask
  task automatic set_res(input int r);
    res = r;
    {res_hi, res_lo} = 2'(r);
  endtask
  // Write n data bytes to pointer p, then compare
  task automatic wr(input int p, input logic [15:0] v, input int n);
    logic [7:0] r;
    logic a;
    int was, m;
    was = pulses;
    tlr_master_i.start();
    tlr_master_i.xfer({tlr_pkg::DEV_ADDR_FIXED, apins, 1'b0}, 1'b1, r, a);
    chk1(a, 1'b0);
    tlr_master_i.xfer(8'(p), 1'b1, r, a);
    chk1(a, 1'b0);
    for (int k = 0; k < n; k++) begin
      tlr_master_i.xfer(k[0] ? v[7:0] : v[15:8], 1'b1, r, a);
      chk1(a, guard.busy);
    end
    tlr_master_i.stop();
    ptr = p;
    m = msk(int'(v));
    // Only a whole, unguarded write changes a limit
    if (n >= 2 && guard === 3'h0 && p == 2 && exp_lo != m) begin
      exp_lo = m;
      was++;
    end
    if (n >= 2 && guard === 3'h0 && p == 3 && exp_hi != m) begin
      exp_hi = m;
      was++;
    end
    chk16(lim.low, exp_lo);
    chk16(lim.high, exp_hi);
    chk16(16'(pulses), was);
  endtask
  // Read the pointed register reps times
  task automatic rd(input int reps);
    logic [7:0] hb, lb;
    logic a;
    int e;
    e = msk((ptr == 2) ? exp_lo : (ptr == 3) ? exp_hi : 0);
    tlr_master_i.start();
    tlr_master_i.xfer({tlr_pkg::DEV_ADDR_FIXED, apins, 1'b1}, 1'b1, hb, a);
    chk1(a, 1'b0);
    for (int k = 0; k < reps; k++) begin
      tlr_master_i.xfer(8'hff, 1'b0, hb, a);
      tlr_master_i.xfer(8'hff, k == reps - 1, lb, a);
      chk16({hb, lb}, e);
    end
    chk1(sda_oe_o, 1'b0);
    tlr_master_i.stop();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==================================================
  // Main sequence
  initial begin
    t = rnd();
    nv.high = {1'b0, t[14:0]};
    nv.low = {1'b1, t[30:16]};
    apins = 3'(rnd());
    exp_hi = nv.high;
    exp_lo = nv.low;
    ptr = 0;
    set_res(0);
    repeat (6) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    nv = nv ^ 32'h7fff_7fff; // Copies move after reset; signs kept so high stays above low
    tlr_master_i.hold(10);
    chk16(lim.low, exp_lo);
    chk16(lim.high, exp_hi);
    rd(1);
    for (int r = 0; r < 4; r++) begin
      set_res(r);
      wr(2, 16'(rnd()) | 16'h8000, 2);
      rd(1);
      wr(3, 16'(rnd()) & 16'h7fff, 2);
      rd(2);
    end
    wr(3, 16'(exp_hi), 2);
    set_res(0);
    rd(1);
    wr(2, 16'(rnd()) | 16'h8000, 3);
    wr(3, 16'(rnd()), 1);
    for (int g = 0; g < 3; g++) begin
      guard = 3'(1 << g);
      wr(2, 16'(rnd()), 2);
    end
    guard = 3'h0;
    tlr_master_i.start();
    tlr_master_i.xfer({tlr_pkg::DEV_ADDR_FIXED, ~apins, 1'b0}, 1'b1, t[7:0], t[8]);
    chk1(t[8], 1'b1);
    tlr_master_i.stop();
    rd(1);
    // Restart after one data byte must leave the low limit alone
    tlr_master_i.start();
    tlr_master_i.xfer({tlr_pkg::DEV_ADDR_FIXED, apins, 1'b0}, 1'b1, t[7:0], t[8]);
    tlr_master_i.xfer(tlr_pkg::PTR_LOW, 1'b1, t[7:0], t[8]);
    tlr_master_i.xfer(8'(rnd()), 1'b1, t[7:0], t[8]);
    ptr = 2;
    rd(1);
    chk16(lim.low, exp_lo);
    // Second reset reloads the moved copies and clears the pointer
    reset_i = 1'b1;
    tlr_master_i.hold(6);
    reset_i = 1'b0;
    exp_lo = nv.low;
    exp_hi = nv.high;
    ptr = 0;
    tlr_master_i.hold(10);
    chk16(lim.low, exp_lo);
    chk16(lim.high, exp_hi);
    rd(1);
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    finish_test();
  end
endmodule
